/* rtl/icsc_pkg.sv */
// Purpose: constants for the interrupt controller status and command registers
// Assumes: 32 sources, register port with byte addresses, 32-bit data
// Notes: offsets are byte addresses of aligned words
package icsc_pkg;
  localparam int NSRC = 32;
  localparam int AW = 9;
  localparam int DW = 32;
  localparam logic [AW-1:0] OFF_HANDLER_BASE = 9'h080;
  localparam logic [AW-1:0] OFF_MODE_BASE = 9'h000;
  localparam logic [AW-1:0] OFF_ACTIVE_VECTOR = 9'h100;
  localparam logic [AW-1:0] OFF_FAST_VECTOR = 9'h104;
  localparam logic [AW-1:0] OFF_SERVICE_STATUS = 9'h108;
  localparam logic [AW-1:0] OFF_PENDING = 9'h10C;
  localparam logic [AW-1:0] OFF_MASK = 9'h110;
  localparam logic [AW-1:0] OFF_CORE_LINE = 9'h114;
  localparam logic [AW-1:0] OFF_ENABLE_CMD = 9'h120;
  localparam logic [AW-1:0] OFF_DISABLE_CMD = 9'h124;
  localparam logic [AW-1:0] OFF_CLEAR_CMD = 9'h128;
  localparam logic [AW-1:0] OFF_SET_CMD = 9'h12C;
  localparam logic [AW-1:0] OFF_EOS_CMD = 9'h130;
  localparam logic [AW-1:0] OFF_STRAY = 9'h134;
  localparam logic [AW-1:0] OFF_DEBUG = 9'h138;
  localparam logic [AW-1:0] OFF_FF_ENABLE = 9'h140;
  localparam logic [AW-1:0] OFF_FF_DISABLE = 9'h144;
  localparam logic [AW-1:0] OFF_FF_STATUS = 9'h148;
  localparam logic [AW-1:0] OFF_IRQ_STATUS = 9'h150;
  localparam logic [AW-1:0] OFF_IRQ_MASK = 9'h154;
  localparam int DBG_SAFE_BIT = 0;
  localparam int DBG_GMASK_BIT = 1;
  localparam int FAST_SRC = 0;
  localparam int PRIO_W = 3;
  localparam logic [DW-1:0] RST_ZERO = 32'h0000_0000;
  localparam logic [DW-1:0] FF_VALID_MASK = 32'hFFFF_FFFE;
  localparam logic [4:0] ID_NONE = 5'h00;
  localparam int EV_W = 2;
  localparam int EV_EOS = 0;
  localparam int EV_STRAY_READ = 1;
  typedef enum logic [1:0] {ICSC_IDLE = 2'b00, ICSC_SERVICE = 2'b01} icsc_state_t;
endpackage : icsc_pkg

/* rtl/icsc_top.sv */
// Purpose: status and command register bank of a 32-source vectored interrupt controller
// Assumes: sources are synchronous-to-clock level requests from logic; one clock
// Notes: sources are high-level sensitive; pending is latched and cleared by command or service
// What this block does
// - status read returns current serviced source number
// - pending register, one bit per source
// - mask register shows enables, resets zero
// - core line status reflects both request lines
// - enable command sets mask bits on ones
// - disable command clears mask bits on ones
// - clear command removes pending on ones
// - set command makes sources pending on ones
// - any write to end-of-service completes service
// - stray vector stored, returned on spurious reads
// - debug bit 0 is stored and read back, drives no logic
// - debug bit 1 holds request lines inactive
// - fast-force enable command, bit 0 reserved
// - active vector read indexes by best normal candidate
// - fast vector read returns entry zero
// - non-fast sources carry priority zero to seven
`timescale 1ns/100ps
module icsc_top #(
  parameter int NSRC = icsc_pkg::NSRC
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [NSRC-1:0] i_src,
  input wire logic [icsc_pkg::AW-1:0] i_addr,
  input wire logic [icsc_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [icsc_pkg::DW-1:0] o_rdata,
  output logic o_fast_req_n,
  output logic o_norm_req_n,
  output logic o_irq
);
  import icsc_pkg::*;

  logic [NSRC-1:0] pending_reg;
  logic [NSRC-1:0] mask_reg;
  logic [NSRC-1:0] ff_reg;
  logic [DW-1:0] handler_reg [NSRC];
  logic [PRIO_W-1:0] prio_reg [NSRC];
  logic [DW-1:0] stray_reg;
  logic [1:0] debug_reg;
  logic [4:0] cur_id_reg;
  icsc_state_t state_reg;
  logic [EV_W-1:0] evst_reg;
  logic [EV_W-1:0] evmask_reg;
  logic [DW-1:0] rdata_next;
  logic fast_req_next;
  logic norm_req_next;
  logic [NSRC-1:0] norm_cand;
  logic [4:0] best_id;
  logic best_hit;
  logic [PRIO_W-1:0] best_prio;
  logic w_en, w_dis, w_clr, w_set, w_eos, w_ffe, w_ffd;
  logic rd_active;
  logic [EV_W-1:0] ev_now;

  // command decodes
  assign w_en = i_wr && (i_addr == OFF_ENABLE_CMD);
  assign w_dis = i_wr && (i_addr == OFF_DISABLE_CMD);
  assign w_clr = i_wr && (i_addr == OFF_CLEAR_CMD);
  assign w_set = i_wr && (i_addr == OFF_SET_CMD);
  assign w_eos = i_wr && (i_addr == OFF_EOS_CMD);
  assign w_ffe = i_wr && (i_addr == OFF_FF_ENABLE);
  assign w_ffd = i_wr && (i_addr == OFF_FF_DISABLE);
  assign rd_active = i_rd && (i_addr == OFF_ACTIVE_VECTOR);

  // mask register, disable wins over enable on same bit
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      mask_reg <= '0;
    end else if (i_ce) begin
      if (w_en) mask_reg <= mask_reg | i_wdata[NSRC-1:0];
      if (w_dis) mask_reg <= mask_reg & ~i_wdata[NSRC-1:0];
    end
  end

  // fast forcing state, bit 0 reserved
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ff_reg <= '0;
    end else if (i_ce) begin
      if (w_ffe) ff_reg <= ff_reg | (i_wdata[NSRC-1:0] & FF_VALID_MASK[NSRC-1:0]);
      if (w_ffd) ff_reg <= ff_reg & ~i_wdata[NSRC-1:0];
    end
  end

  // pending: source level and set win over clear and service acknowledge
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      pending_reg <= '0;
    end else if (i_ce) begin
      pending_reg <= (pending_reg
                      & ~(w_clr ? i_wdata[NSRC-1:0] : '0)
                      & ~((rd_active && best_hit) ? (NSRC'(1) << best_id) : '0)
                      & ~((i_rd && i_addr == OFF_FAST_VECTOR) ? NSRC'(1) : '0))
                     | i_src
                     | (w_set ? i_wdata[NSRC-1:0] : '0);
    end
  end

  // per-source handler table and priorities
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
          handler_reg[g] <= RST_ZERO;
          prio_reg[g] <= '0;
        end else if (i_ce && i_wr) begin
          if (i_addr == OFF_HANDLER_BASE + AW'(4 * g)) handler_reg[g] <= i_wdata;
          if (i_addr == OFF_MODE_BASE + AW'(4 * g) && g != FAST_SRC) prio_reg[g] <= i_wdata[PRIO_W-1:0];
        end
      end
      assign norm_cand[g] = pending_reg[g] && mask_reg[g] && !ff_reg[g] && (g != FAST_SRC);
    end
  endgenerate

  // highest priority normal candidate, lowest number wins ties
  always_comb begin
    best_hit = 1'b0;
    best_id = ID_NONE;
    best_prio = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (norm_cand[i] && (!best_hit || prio_reg[i] > best_prio)) begin
        best_hit = 1'b1;
        best_id = 5'(i);
        best_prio = prio_reg[i];
      end
    end
  end

  // service tracking: acknowledge on vector read, end on service write
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state_reg <= ICSC_IDLE;
      cur_id_reg <= ID_NONE;
    end else if (i_ce) begin
      case (state_reg)
        ICSC_IDLE: begin
          if (rd_active && best_hit) begin
            state_reg <= ICSC_SERVICE;
            cur_id_reg <= best_id;
          end
        end
        ICSC_SERVICE: begin
          if (w_eos) state_reg <= ICSC_IDLE;
        end
        default: state_reg <= ICSC_IDLE;
      endcase
    end
  end

  // debug control and stray vector
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      debug_reg <= 2'h0;
      stray_reg <= RST_ZERO;
    end else if (i_ce && i_wr) begin
      if (i_addr == OFF_DEBUG) debug_reg <= i_wdata[1:0];
      if (i_addr == OFF_STRAY) stray_reg <= i_wdata;
    end
  end

  // request line next values, active high internally
  always_comb begin
    fast_req_next = (pending_reg[FAST_SRC] && mask_reg[FAST_SRC]) || |(pending_reg & mask_reg & ff_reg);
    norm_req_next = best_hit && (state_reg == ICSC_IDLE);
    if (debug_reg[DBG_GMASK_BIT]) begin
      fast_req_next = 1'b0;
      norm_req_next = 1'b0;
    end
  end

  // request lines, active low to the core
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_fast_req_n <= 1'b1;
      o_norm_req_n <= 1'b1;
    end else if (i_ce) begin
      o_fast_req_n <= !fast_req_next;
      o_norm_req_n <= !norm_req_next;
    end
  end

  // block events: service end and stray vector read
  assign ev_now[EV_EOS] = w_eos && state_reg == ICSC_SERVICE;
  assign ev_now[EV_STRAY_READ] = rd_active && !best_hit;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      evst_reg <= '0;
      evmask_reg <= '0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      evst_reg <= (evst_reg & ~((i_wr && i_addr == OFF_IRQ_STATUS) ? i_wdata[EV_W-1:0] : '0)) | ev_now;
      if (i_wr && i_addr == OFF_IRQ_MASK) evmask_reg <= i_wdata[EV_W-1:0];
      o_irq <= |(evst_reg & evmask_reg);
    end
  end

  // read mux
  always_comb begin
    rdata_next = RST_ZERO;
    case (i_addr)
      OFF_ACTIVE_VECTOR: rdata_next = best_hit ? handler_reg[best_id] : stray_reg;
      OFF_FAST_VECTOR: rdata_next = fast_req_next ? handler_reg[FAST_SRC] : stray_reg;
      OFF_SERVICE_STATUS: rdata_next = {27'h0, cur_id_reg};
      OFF_PENDING: rdata_next = pending_reg;
      OFF_MASK: rdata_next = mask_reg;
      OFF_CORE_LINE: rdata_next = {30'h0, !o_norm_req_n, !o_fast_req_n};
      OFF_STRAY: rdata_next = stray_reg;
      OFF_DEBUG: rdata_next = {30'h0, debug_reg};
      OFF_FF_STATUS: rdata_next = ff_reg;
      OFF_IRQ_STATUS: rdata_next = {30'h0, evst_reg};
      OFF_IRQ_MASK: rdata_next = {30'h0, evmask_reg};
      default: begin
        for (int i = 0; i < NSRC; i++) begin
          if (i_addr == OFF_HANDLER_BASE + AW'(4 * i)) rdata_next = handler_reg[i];
          if (i_addr == OFF_MODE_BASE + AW'(4 * i)) rdata_next = {29'h0, prio_reg[i]};
        end
      end
    endcase
  end

  // read data register
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) o_rdata <= RST_ZERO;
    else if (i_ce) o_rdata <= i_rd ? rdata_next : RST_ZERO;
  end

  // checks: mask and fast forcing commands
  AST_MASK_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && w_en && !w_dis |=> (mask_reg & $past(i_wdata)) == $past(i_wdata))
    else $error("enable did not set mask");
  AST_MASK_KEEP: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && w_en && !w_dis
      |=> (mask_reg & ~$past(i_wdata)) == ($past(mask_reg) & ~$past(i_wdata)))
    else $error("enable changed a bit written as zero");
  AST_MASK_CLR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && w_dis |=> (mask_reg & $past(i_wdata)) == '0)
    else $error("disable did not clear mask");
  AST_MASK_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && w_dis && !w_en
      |=> (mask_reg & ~$past(i_wdata)) == ($past(mask_reg) & ~$past(i_wdata)))
    else $error("disable changed a bit written as zero");
  AST_FF_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && w_ffe && !w_ffd
      |=> (ff_reg & $past(i_wdata) & FF_VALID_MASK) == ($past(i_wdata) & FF_VALID_MASK))
    else $error("fast force enable did not take");
  AST_FF_RSV: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ff_reg[0] == 1'b0)
    else $error("reserved fast force bit set");
  // checks: pending commands and source levels
  AST_SET_PEND: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && w_set |=> (pending_reg & $past(i_wdata)) == $past(i_wdata))
    else $error("set did not make pending");
  AST_CLR_PEND: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && w_clr && !w_set && i_src == '0 && !i_rd |=> (pending_reg & $past(i_wdata)) == '0)
    else $error("clear did not remove pending");
  AST_CLR_KEEP: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && w_clr && !i_rd |=> ($past(pending_reg) & ~$past(i_wdata) & ~pending_reg) == '0)
    else $error("clear removed a source written as zero");
  AST_PEND_SRC: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce |=> (pending_reg & $past(i_src)) == $past(i_src))
    else $error("active source not pending");
  // checks: values held during and after reset
  AST_RST_VAL: assert property (@(posedge i_ref_clk)
    !i_rstn |=> mask_reg == '0 && pending_reg == '0 && debug_reg == 2'h0
      && stray_reg == RST_ZERO && o_rdata == RST_ZERO)
    else $error("register not cleared by reset");
  AST_RST_LINES: assert property (@(posedge i_ref_clk)
    !i_rstn |=> o_fast_req_n && o_norm_req_n && !o_irq)
    else $error("line active after reset");
  // checks: register reads, data one cycle after the strobe
  AST_PEND_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && i_rd && i_addr == OFF_PENDING |=> o_rdata == $past(pending_reg))
    else $error("pending read wrong");
  AST_MASK_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && i_rd && i_addr == OFF_MASK |=> o_rdata == $past(mask_reg))
    else $error("mask read wrong");
  AST_CORE_LINE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && i_rd && i_addr == OFF_CORE_LINE |=> o_rdata[1:0] == {!$past(o_norm_req_n), !$past(o_fast_req_n)})
    else $error("core line status wrong");
  AST_ID_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && i_rd && i_addr == OFF_SERVICE_STATUS |=> o_rdata == {27'h0, $past(cur_id_reg)})
    else $error("service status read wrong");
  AST_DEBUG_READ: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && i_rd && i_addr == OFF_DEBUG |=> o_rdata[1:0] == $past(debug_reg))
    else $error("debug control read wrong");
  AST_STRAY: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && rd_active && !best_hit |=> o_rdata == $past(stray_reg))
    else $error("stray vector not returned");
  AST_ACTIVE_VEC: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && rd_active && best_hit |=> o_rdata == $past(handler_reg[best_id]))
    else $error("active vector not from handler table");
  AST_FAST_VEC: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && i_rd && i_addr == OFF_FAST_VECTOR && fast_req_next
      |=> o_rdata == $past(handler_reg[FAST_SRC]))
    else $error("fast vector not entry zero");
  AST_FAST_STRAY: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && i_rd && i_addr == OFF_FAST_VECTOR && !fast_req_next
      |=> o_rdata == $past(stray_reg))
    else $error("spurious fast read did not give stray vector");
  AST_RDATA_IDLE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && !i_rd |=> o_rdata == RST_ZERO)
    else $error("read data not zero without a read");
  // checks: request lines, service and events
  AST_GMASK: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && debug_reg[DBG_GMASK_BIT] |=> o_fast_req_n && o_norm_req_n)
    else $error("global mask let a line through");
  AST_FAST_LINE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && !debug_reg[DBG_GMASK_BIT] && pending_reg[FAST_SRC] && mask_reg[FAST_SRC]
      |=> !o_fast_req_n)
    else $error("fast line not raised for source zero");
  AST_FORCE_LINE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && !debug_reg[DBG_GMASK_BIT] && (pending_reg & mask_reg & ff_reg) != '0
      |=> !o_fast_req_n)
    else $error("forced source did not raise fast line");
  AST_FORCE_QUIET: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && (pending_reg & mask_reg & ~ff_reg & ~NSRC'(1)) == '0
      |=> o_norm_req_n)
    else $error("normal line raised with no unforced candidate");
  AST_NORM_SERVICE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && state_reg == ICSC_SERVICE |=> o_norm_req_n)
    else $error("normal line raised during service");
  AST_ID: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && rd_active && best_hit && state_reg == ICSC_IDLE |=> cur_id_reg == $past(best_id))
    else $error("current id not captured");
  AST_EOS: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && w_eos && state_reg == ICSC_SERVICE |=> state_reg == ICSC_IDLE)
    else $error("service write did not end service");
  AST_EOS_EVENT: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && w_eos && state_reg == ICSC_SERVICE |=> evst_reg[EV_EOS])
    else $error("end of service event not flagged");
  AST_PRIO_FAST: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce && i_wr && i_addr == OFF_MODE_BASE |=> prio_reg[FAST_SRC] == '0)
    else $error("fast source took a priority");
  AST_IRQ_LEVEL: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_ce |=> o_irq == $past(|(evst_reg & evmask_reg)))
    else $error("interrupt output does not follow unmasked status");
  // covers for the main scenarios
  COV_SERVICE: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
    state_reg == ICSC_SERVICE ##[1:20] state_reg == ICSC_IDLE);
  COV_FAST: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) !o_fast_req_n);
  COV_NORM: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) !o_norm_req_n);
  COV_IRQ: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_irq);
  COV_FORCED: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) !o_fast_req_n && ff_reg != '0);
endmodule : icsc_top

/* test/icsc_src_model.sv */
// Purpose: far-side model of the peripheral sources that feed the controller
// Assumes: sources are high levels on the controller clock, no synchroniser needed
// Notes: levels move right after an edge, as a peripheral flop would
`timescale 1ns/100ps
module icsc_src_model (
  input wire logic i_ref_clk,
  input wire logic [31:0] i_level,
  output logic [31:0] o_src
);
  // one flop per peripheral request line, no reset, follows the level after each edge
  always @(posedge i_ref_clk) begin
    o_src <= i_level;
  end
endmodule : icsc_src_model

/* test/tb_icsc_top.sv */
// Purpose: self-checking bench for the interrupt controller register bank
// Assumes: one 50 MHz clock, synchronous active-low reset held 16 cycles
// Notes: register tasks speak the plain strobe port; line checks pack {fast_n, norm_n, irq}
`timescale 1ns/100ps
module tb_icsc_top;
  import icsc_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rstn;
  logic i_ce;
  logic [31:0] lvl;
  logic [31:0] src;
  logic [AW-1:0] i_addr;
  logic [DW-1:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [DW-1:0] o_rdata;
  logic o_fast_req_n;
  logic o_norm_req_n;
  logic o_irq;
  int fails;
  int n_compared;

  // free-running 20 ns clock
  always #10 i_ref_clk = ~i_ref_clk;

  icsc_src_model i_icsc_src_model (.i_ref_clk(i_ref_clk), .i_level(lvl), .o_src(src));
  icsc_top #(.NSRC(32)) i_icsc_top (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_src(src),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_fast_req_n(o_fast_req_n), .o_norm_req_n(o_norm_req_n), .o_irq(o_irq));

  // register and line comparisons
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_ln(input logic [2:0] exp);
    repeat (3) @(posedge i_ref_clk);
    #1;
    n_compared++;
    if ({o_fast_req_n, o_norm_req_n, o_irq} !== exp) begin
      fails++;
      $display("mismatch at %0t: lines %b expected %b", $time, {o_fast_req_n, o_norm_req_n, o_irq}, exp);
    end
  endtask : cmp_ln
  // one-cycle write and read strobes
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    cmp(o_rdata, e);
  endtask : rd
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // watchdog well beyond the expected run of under two hundred cycles
  initial begin
    repeat (4000) @(posedge i_ref_clk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end

  // main sequence
  initial begin
    i_rstn = 1'b0;
    i_ce = 1'b1;
    lvl = 32'h0000_0000;
    i_addr = '0;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (16) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    rd(OFF_PENDING, 32'h0000_0000);
    rd(OFF_MASK, 32'h0000_0000);
    rd(OFF_CORE_LINE, 32'h0000_0000);
    rd(OFF_STRAY, 32'h0000_0000);
    rd(OFF_DEBUG, 32'h0000_0000);
    rd(9'h118, 32'h0000_0000);
    $display("test reset values done");
    wr(OFF_ENABLE_CMD, 32'h0000_00F0);
    wr(OFF_ENABLE_CMD, 32'h0000_0F00);
    rd(OFF_MASK, 32'h0000_0FF0);
    wr(OFF_DISABLE_CMD, 32'h0000_0030);
    rd(OFF_MASK, 32'h0000_0FC0);
    wr(OFF_DISABLE_CMD, 32'hFFFF_FFFF);
    rd(OFF_MASK, 32'h0000_0000);
    $display("test mask commands done");
    wr(OFF_STRAY, 32'h5A5A_0000);
    rd(OFF_STRAY, 32'h5A5A_0000);
    rd(OFF_FAST_VECTOR, 32'h5A5A_0000);
    rd(OFF_ACTIVE_VECTOR, 32'h5A5A_0000);
    rd(OFF_IRQ_STATUS, 32'h0000_0002);
    cmp_ln(3'b110);
    wr(OFF_IRQ_MASK, 32'h0000_0002);
    cmp_ln(3'b111);
    wr(OFF_IRQ_STATUS, 32'h0000_0002);
    cmp_ln(3'b110);
    $display("test stray vector and event done");
    wr(OFF_HANDLER_BASE + 9'h00C, 32'h0000_3330);
    wr(OFF_HANDLER_BASE + 9'h010, 32'h0000_4440);
    wr(OFF_MODE_BASE + 9'h00C, 32'h0000_0001);
    wr(OFF_MODE_BASE + 9'h010, 32'h0000_0007);
    wr(OFF_ENABLE_CMD, 32'h0000_0018);
    wr(OFF_SET_CMD, 32'h0000_0018);
    rd(OFF_PENDING, 32'h0000_0018);
    cmp_ln(3'b100);
    rd(OFF_CORE_LINE, 32'h0000_0002);
    rd(OFF_ACTIVE_VECTOR, 32'h0000_4440);
    rd(OFF_SERVICE_STATUS, 32'h0000_0004);
    rd(OFF_PENDING, 32'h0000_0008);
    cmp_ln(3'b110);
    wr(OFF_CLEAR_CMD, 32'h0000_0008);
    rd(OFF_PENDING, 32'h0000_0000);
    wr(OFF_EOS_CMD, 32'hDEAD_BEEF);
    rd(OFF_IRQ_STATUS, 32'h0000_0001);
    wr(OFF_IRQ_STATUS, 32'h0000_0001);
    $display("test service cycle done");
    wr(OFF_SET_CMD, 32'h0000_0008);
    cmp_ln(3'b100);
    wr(OFF_DEBUG, 32'h0000_0002);
    cmp_ln(3'b110);
    rd(OFF_CORE_LINE, 32'h0000_0000);
    rd(OFF_DEBUG, 32'h0000_0002);
    wr(OFF_DEBUG, 32'h0000_0001);
    rd(OFF_DEBUG, 32'h0000_0001);
    cmp_ln(3'b100);
    wr(OFF_CLEAR_CMD, 32'h0000_0008);
    wr(OFF_DEBUG, 32'h0000_0000);
    $display("test debug control done");
    wr(OFF_HANDLER_BASE, 32'h0F0F_0000);
    wr(OFF_ENABLE_CMD, 32'h0000_0001);
    wr(OFF_SET_CMD, 32'h0000_0001);
    cmp_ln(3'b010);
    rd(OFF_CORE_LINE, 32'h0000_0001);
    rd(OFF_FAST_VECTOR, 32'h0F0F_0000);
    cmp_ln(3'b110);
    @(posedge i_ref_clk);
    lvl <= 32'h0000_0004;
    wr(OFF_ENABLE_CMD, 32'h0000_0004);
    wr(OFF_FF_ENABLE, 32'h0000_0005);
    rd(OFF_FF_STATUS, 32'h0000_0004);
    cmp_ln(3'b010);
    rd(OFF_PENDING, 32'h0000_0004);
    @(posedge i_ref_clk);
    lvl <= 32'h0000_0000;
    wr(OFF_CLEAR_CMD, 32'h0000_0004);
    rd(OFF_PENDING, 32'h0000_0000);
    $display("test fast path done");
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    wr(OFF_ENABLE_CMD, 32'h0000_0020);
    i_ce <= 1'b1;
    rd(OFF_MASK, 32'h0000_001D);
    $display("test clock enable freeze done");
    close_out();
  end
endmodule : tb_icsc_top
